// File: common/ssbi_defs.svh
// Constants of the synchronous burst memory interface
`ifndef SSBI_DEFS_SVH
`define SSBI_DEFS_SVH

`define SSBI_ADDR_W         21
`define SSBI_DATA_W         18
`define SSBI_LANE_W         9
`define SSBI_LO_LSB         0
`define SSBI_HI_LSB         9
`define SSBI_BURST_W        2
`define SSBI_FIFO_DEPTH     16
`define SSBI_SYNC_STAGES    3
`define SSBI_RD_LATENCY     2
`define SSBI_WAKE_SETTLE_CYCLES  2
`define SSBI_SLEEP_ENTRY_CYCLES  2
`define SSBI_PIN_RESET      3'h3
`define SSBI_PIN_SLEEP      2
`define SSBI_PIN_OE_N       1
`define SSBI_PIN_ORDER      0
`define SSBI_DATA_RESET     18'h00000

`endif

// File: common/ssbi_pkg.sv
// Types of the synchronous burst memory interface
package ssbi_pkg;

  typedef enum logic [4:0] {
    SSBI_ST_IDLE  = 5'h01,
    SSBI_ST_DESEL = 5'h02,
    SSBI_ST_READ  = 5'h04,
    SSBI_ST_WRITE = 5'h08,
    SSBI_ST_SLEEP = 5'h10
  } ssbi_state_t;

  typedef enum logic [1:0] {
    SSBI_OP_NONE  = 2'h0,
    SSBI_OP_READ  = 2'h1,
    SSBI_OP_WRITE = 2'h2,
    SSBI_OP_ABORT = 2'h3
  } ssbi_op_t;

endpackage

// File: core/ssbi_fifo.sv
// Pending write queue between the data pins and the storage array
`timescale 1ns/10ps
module ssbi_fifo #(
  parameter int W     = 41,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
  } ssbi_fifo_st_t;

  ssbi_fifo_st_t st;
  ssbi_fifo_st_t nxt_st;
  logic [W-1:0]  mem_q [0:DEPTH-1];
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  assign full  = (st.wr_ptr_ff[AW] != st.rd_ptr_ff[AW]) &&
                 (st.wr_ptr_ff[AW-1:0] == st.rd_ptr_ff[AW-1:0]);
  assign empty = (st.wr_ptr_ff == st.rd_ptr_ff);
  assign push  = in_valid_i & ~full;
  assign pop   = out_ready_i & ~empty;

  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_q[st.rd_ptr_ff[AW-1:0]];

  always_comb begin
    nxt_st = st;
    if (push) begin
      nxt_st.wr_ptr_ff = (AW+1)'(st.wr_ptr_ff + 1'b1);
    end
    if (pop) begin
      nxt_st.rd_ptr_ff = (AW+1)'(st.rd_ptr_ff + 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= nxt_st;
    end
  end

  // Storage needs no reset; entries are only read once written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[st.wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end

endmodule // ssbi_fifo

// File: core/ssbi_burst_ctr.sv
// Two-bit burst address counter, interleaved or linear order
`timescale 1ns/10ps
`include "ssbi_defs.svh"
module ssbi_burst_ctr (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  // Control
  input  wire logic                     load_i,
  input  wire logic                     step_i,
  input  wire logic                     linear_i,
  input  wire logic [`SSBI_BURST_W-1:0] start_i,
  // Address
  output logic [`SSBI_BURST_W-1:0]      cur_o,
  output logic [`SSBI_BURST_W-1:0]      next_o
);

  typedef struct packed {
    logic [`SSBI_BURST_W-1:0] start_ff;
    logic [`SSBI_BURST_W-1:0] cnt_ff;
  } ssbi_ctr_st_t;

  ssbi_ctr_st_t             st;
  ssbi_ctr_st_t             nxt_st;
  logic [`SSBI_BURST_W-1:0] cnt_inc;

  // Two-bit count wraps to the loaded start every fourth step
  assign cnt_inc = `SSBI_BURST_W'(st.cnt_ff + 2'h1);

  always_comb begin
    if (linear_i) begin
      cur_o  = `SSBI_BURST_W'(st.start_ff + st.cnt_ff);
      next_o = `SSBI_BURST_W'(st.start_ff + cnt_inc);
    end else begin
      cur_o  = st.start_ff ^ st.cnt_ff;
      next_o = st.start_ff ^ cnt_inc;
    end
  end

  always_comb begin
    nxt_st = st;
    if (load_i) begin
      nxt_st.start_ff = start_i;
      nxt_st.cnt_ff   = 2'h0;
    end else if (step_i) begin
      nxt_st.cnt_ff = cnt_inc;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= nxt_st;
    end
  end

endmodule // ssbi_burst_ctr

// File: core/ssbi_top.sv
// Synchronous burst memory device: cycle decode, pipeline, storage
`timescale 1ns/10ps
`include "ssbi_defs.svh"

// Summary of operation
// - Sleep follows sleep request high after synchronizing; leave when low.
// - Sleep request is asynchronous, active high, the only way into sleep.
// - Asleep: ignore all but sleep request, data outputs floating.
// - Order select high: burst address is start XOR step count.
// - Order select low: burst address adds one modulo four per step.
// - Two-bit burst counter wraps to loaded address every fourth step.
// - Load with any chip select inactive is a deselect; bus floats.
// - Advance after deselect stays deselected; reachable after a deselect or from sleep.
// - Load, all selected, read select high: read burst from address.
// - Read data out, write data taken, two cycles after command.
// - Read with output enable high is dummy; bus floats.
// - Load, all selected, write select, a strobe low: write burst.
// - Write with all byte strobes high is aborted; nothing changes.
// - Advance keeps burst type, ignores read select, steps counter.
// - Each byte strobe writes only its own byte lane.
// - Clock hold freezes state and address; no write; bus unchanged.
// - Output drivers are off during writes without output enable help.
// - Data outputs float from power-up until a valid read.
// - Deselect lets already pending reads and writes complete.
module ssbi_top (
  // Clock and reset
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    NRST_I,
  // Command pins
  input  wire logic [`SSBI_ADDR_W-1:0] ADDR_I,
  input  wire logic                    BURST_STEP_OR_LOAD_I,
  input  wire logic                    CLOCK_HOLD_N_I,
  input  wire logic                    CHIP_SELECT_A_N_I,
  input  wire logic                    CHIP_SELECT_B_I,
  input  wire logic                    CHIP_SELECT_C_N_I,
  input  wire logic                    READ_WRITE_N_I,
  input  wire logic                    BYTE_WRITE_LO_N_I,
  input  wire logic                    BYTE_WRITE_HI_N_I,
  // Asynchronous pins
  input  wire logic                    OUT_ENABLE_N_I,
  input  wire logic                    BURST_ORDER_SELECT_I,
  input  wire logic                    SLEEP_REQUEST_I,
  // Data pins
  input  wire logic [`SSBI_DATA_W-1:0] DATA_I,
  output logic [`SSBI_DATA_W-1:0]      DATA_O,
  output logic                         DATA_OE_O,
  // Status
  output logic                         SLEEP_ACTIVE_O
);

  localparam int FW = `SSBI_ADDR_W + `SSBI_DATA_W + 2;

  typedef struct packed {
    logic [2:0][`SSBI_SYNC_STAGES-1:0] sync_ff;
    logic [2:0]                        lvl_ff;
    ssbi_pkg::ssbi_state_t             state_ff;
    ssbi_pkg::ssbi_op_t                s1_op_ff;
    logic [`SSBI_ADDR_W-1:0]           s1_addr_ff;
    logic [1:0]                        s1_bw_ff;
    ssbi_pkg::ssbi_op_t                s2_op_ff;
    logic [`SSBI_ADDR_W-1:0]           s2_addr_ff;
    logic [1:0]                        s2_bw_ff;
    logic [`SSBI_ADDR_W-1:2]           hi_addr_ff;
    logic [`SSBI_DATA_W-1:0]           dq_ff;
    logic                              drive_ff;
  } ssbi_top_st_t;

  ssbi_top_st_t            st;
  ssbi_top_st_t            nxt_st;
  logic [`SSBI_DATA_W-1:0] mem_q [0:(2**`SSBI_ADDR_W)-1];

  logic                    asleep;
  logic                    oe_n_lvl;
  logic                    linear;
  logic                    is_load;
  logic                    sel_ok;
  logic                    any_bw;
  logic                    fifo_in_ready;
  logic                    hold;
  logic                    take;
  logic                    push;
  logic                    pop;
  logic                    cnt_load;
  logic                    cnt_step;
  logic [1:0]              burst_cur;
  logic [1:0]              burst_next;
  logic [1:0]              bw_now;
  logic [2:0]              pin_raw;
  ssbi_pkg::ssbi_op_t      issue;
  ssbi_pkg::ssbi_state_t   nxt_state;
  logic [`SSBI_ADDR_W-1:0] issue_addr;
  logic [FW-1:0]           fifo_in;
  logic [FW-1:0]           fifo_out;
  logic                    fifo_out_valid;
  logic [`SSBI_ADDR_W-1:0] wr_addr;
  logic [`SSBI_DATA_W-1:0] wr_data;
  logic [1:0]              wr_bw;
  logic [`SSBI_DATA_W-1:0] rdata;

  assign pin_raw  = {SLEEP_REQUEST_I, OUT_ENABLE_N_I, BURST_ORDER_SELECT_I};
  assign asleep   = st.lvl_ff[`SSBI_PIN_SLEEP];
  assign oe_n_lvl = st.lvl_ff[`SSBI_PIN_OE_N];
  assign linear   = ~st.lvl_ff[`SSBI_PIN_ORDER];
  assign is_load  = ~BURST_STEP_OR_LOAD_I;
  assign sel_ok   = ~CHIP_SELECT_A_N_I & CHIP_SELECT_B_I &
                    ~CHIP_SELECT_C_N_I;
  assign bw_now   = {~BYTE_WRITE_HI_N_I, ~BYTE_WRITE_LO_N_I};
  assign any_bw   = |bw_now;

  // A full write queue stalls the core exactly like the clock hold pin
  assign hold = CLOCK_HOLD_N_I | ~fifo_in_ready;
  assign take = ~hold & ~asleep;

  // Late write data joins its registered address and strobes
  assign push = take && (st.s2_op_ff == ssbi_pkg::SSBI_OP_WRITE);
  assign fifo_in = {st.s2_addr_ff, DATA_I, st.s2_bw_ff};
  assign pop = fifo_out_valid & ~asleep;
  assign {wr_addr, wr_data, wr_bw} = fifo_out;

  // Cycle decode from the pins and the current burst type
  always_comb begin
    issue     = ssbi_pkg::SSBI_OP_NONE;
    nxt_state = st.state_ff;
    cnt_load  = 1'b0;
    cnt_step  = 1'b0;
    if (is_load) begin
      cnt_load = sel_ok;
      if (!sel_ok) begin
        nxt_state = ssbi_pkg::SSBI_ST_DESEL;
      end else if (READ_WRITE_N_I) begin
        nxt_state = ssbi_pkg::SSBI_ST_READ;
        issue     = ssbi_pkg::SSBI_OP_READ;
      end else begin
        nxt_state = ssbi_pkg::SSBI_ST_WRITE;
        issue     = any_bw ? ssbi_pkg::SSBI_OP_WRITE
                           : ssbi_pkg::SSBI_OP_ABORT;
      end
    end else begin
      unique case (st.state_ff)
        ssbi_pkg::SSBI_ST_IDLE: begin
          nxt_state = ssbi_pkg::SSBI_ST_IDLE;
        end
        ssbi_pkg::SSBI_ST_DESEL: begin
          nxt_state = ssbi_pkg::SSBI_ST_DESEL;
        end
        ssbi_pkg::SSBI_ST_READ: begin
          issue    = ssbi_pkg::SSBI_OP_READ;
          cnt_step = 1'b1;
        end
        ssbi_pkg::SSBI_ST_WRITE: begin
          issue    = any_bw ? ssbi_pkg::SSBI_OP_WRITE
                            : ssbi_pkg::SSBI_OP_ABORT;
          cnt_step = 1'b1;
        end
        ssbi_pkg::SSBI_ST_SLEEP: begin
          nxt_state = ssbi_pkg::SSBI_ST_DESEL;
        end
      endcase
    end
  end

  // Only the two low bits move during a burst
  assign issue_addr = is_load ? ADDR_I
                              : {st.hi_addr_ff, burst_next};

  // Queue-head (oldest) write overlays the array so a read right after sees it
  always_comb begin
    rdata = mem_q[st.s2_addr_ff];
    if (fifo_out_valid && (wr_addr == st.s2_addr_ff)) begin
      if (wr_bw[0]) begin
        rdata[`SSBI_LO_LSB +: `SSBI_LANE_W] =
          wr_data[`SSBI_LO_LSB +: `SSBI_LANE_W];
      end
      if (wr_bw[1]) begin
        rdata[`SSBI_HI_LSB +: `SSBI_LANE_W] =
          wr_data[`SSBI_HI_LSB +: `SSBI_LANE_W];
      end
    end
  end

  always_comb begin
    nxt_st = st;
    for (int i = 0; i < 3; i++) begin
      nxt_st.sync_ff[i] = {st.sync_ff[i][1:0], pin_raw[i]};
      if (st.sync_ff[i][1] == st.sync_ff[i][2]) begin
        nxt_st.lvl_ff[i] = st.sync_ff[i][2];
      end
    end
    if (asleep) begin
      // In-flight work is dropped; the controller must drain first
      nxt_st.state_ff = ssbi_pkg::SSBI_ST_SLEEP;
      nxt_st.s1_op_ff = ssbi_pkg::SSBI_OP_NONE;
      nxt_st.s2_op_ff = ssbi_pkg::SSBI_OP_NONE;
      nxt_st.drive_ff = 1'b0;
    end else if (take) begin
      nxt_st.state_ff = nxt_state;
      nxt_st.s1_op_ff   = issue;
      nxt_st.s1_addr_ff = issue_addr;
      nxt_st.s1_bw_ff   = bw_now;
      if (is_load && sel_ok) begin
        nxt_st.hi_addr_ff = ADDR_I[`SSBI_ADDR_W-1:2];
      end
      // Pipeline drains even after deselect
      nxt_st.s2_op_ff   = st.s1_op_ff;
      nxt_st.s2_addr_ff = st.s1_addr_ff;
      nxt_st.s2_bw_ff   = st.s1_bw_ff;
      nxt_st.drive_ff   = (st.s2_op_ff == ssbi_pkg::SSBI_OP_READ);
      if (st.s2_op_ff == ssbi_pkg::SSBI_OP_READ) begin
        nxt_st.dq_ff = rdata;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st          <= '0;
      st.sync_ff  <= {{`SSBI_SYNC_STAGES{1'b0}}, {`SSBI_SYNC_STAGES{1'b1}},
                      {`SSBI_SYNC_STAGES{1'b1}}};
      st.lvl_ff   <= `SSBI_PIN_RESET;
      st.state_ff <= ssbi_pkg::SSBI_ST_IDLE;
      st.dq_ff    <= `SSBI_DATA_RESET;
      st.drive_ff <= 1'b0;
    end else begin
      st <= nxt_st;
    end
  end

  // Byte-lane write from the queue head
  always_ff @(posedge CORE_CLK_I) begin
    if (pop) begin
      for (int l = 0; l < 2; l++) begin
        if (wr_bw[l]) begin
          mem_q[wr_addr][l*`SSBI_LANE_W +: `SSBI_LANE_W] <=
            wr_data[l*`SSBI_LANE_W +: `SSBI_LANE_W];
        end
      end
    end
  end

  ssbi_burst_ctr u_ctr (
    .clk_i    (CORE_CLK_I),
    .nrst_i   (NRST_I),
    .load_i   (take & cnt_load),
    .step_i   (take & cnt_step),
    .linear_i (linear),
    .start_i  (ADDR_I[1:0]),
    .cur_o    (burst_cur),
    .next_o   (burst_next)
  );

  ssbi_fifo #(
    .W     (FW),
    .DEPTH (`SSBI_FIFO_DEPTH)
  ) u_wq (
    .clk_i       (CORE_CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (~asleep),
    .out_data_o  (fifo_out)
  );

  // Output enable pin gates the drivers; dummy reads never reach the bus
  assign DATA_OE_O      = st.drive_ff & ~oe_n_lvl & ~asleep;
  assign DATA_O         = st.dq_ff;
  assign SLEEP_ACTIVE_O = asleep;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence rd_issue_s;
    take && (issue == ssbi_pkg::SSBI_OP_READ);
  endsequence

  sequence wr_issue_s;
    take && (issue == ssbi_pkg::SSBI_OP_WRITE);
  endsequence

  sequence desel_issue_s;
    take && is_load && !sel_ok;
  endsequence

  sequence load_sel_s;
    take && is_load && sel_ok;
  endsequence

  sleep_float_a: assert property (
    asleep |-> !DATA_OE_O ##1 !st.drive_ff
  ) else $error("Data bus driven while asleep");

  sleep_state_a: assert property (
    asleep |=> (st.state_ff == ssbi_pkg::SSBI_ST_SLEEP)
  ) else $error("Sleep level not reflected in state");

  read_latency_a: assert property (
    rd_issue_s ##1 take ##1 take |=> st.drive_ff
  ) else $error("Read data not ready two cycles after command");

  write_capture_a: assert property (
    wr_issue_s ##1 take ##1 take |-> push
  ) else $error("Write data not taken two cycles after command");

  write_nodrive_a: assert property (
    wr_issue_s ##1 take ##1 take |=> !st.drive_ff
  ) else $error("Drivers on during a write");

  desel_float_a: assert property (
    desel_issue_s ##1 take ##1 take |=> !DATA_OE_O
  ) else $error("Bus driven after deselect");

  hold_freeze_a: assert property (
    (hold && !asleep) |=> $stable(st.s1_op_ff) && $stable(burst_cur)
      && $stable(st.drive_ff)
  ) else $error("State moved during clock hold");

  abort_nopush_a: assert property (
    push |-> (st.s2_bw_ff != 2'h0)
  ) else $error("Aborted write queued");

  burst_wrap_a: assert property (
    load_sel_s ##1 (take && !is_load)[*4]
      |=> (burst_cur == $past(burst_cur, 4))
  ) else $error("Burst did not wrap after four steps");

  linear_step_a: assert property (
    (take && cnt_step && linear && !is_load)
      |=> (burst_cur == 2'($past(burst_cur) + 2'h1))
  ) else $error("Linear burst step wrong");

  idle_stay_a: assert property (
    (take && !is_load && st.state_ff == ssbi_pkg::SSBI_ST_IDLE)
      |=> (st.state_ff == ssbi_pkg::SSBI_ST_IDLE) && (st.s1_op_ff ==
      ssbi_pkg::SSBI_OP_NONE)
  ) else $error("Continue deselect entered without deselect");

endmodule // ssbi_top

// File: verification/ssbi_host.sv
// Host controller model driving the burst memory's pins
`timescale 1ns/10ps
`include "ssbi_defs.svh"
module ssbi_host (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  // Command pins
  output logic [`SSBI_ADDR_W-1:0]      addr_o,
  output logic                         load_n_o,
  output logic                         hold_o,
  output logic [2:0]                   cs_o,
  output logic                         rd_o,
  output logic [1:0]                   bw_n_o,
  output logic [2:0]                   async_o,
  // Data pins
  output logic [`SSBI_DATA_W-1:0]      bus_o,
  input  wire logic [`SSBI_DATA_W-1:0] dout_i,
  input  wire logic                    doe_i
);
  logic [18:0]             wp [3];
  logic [19:0]             xp [4];
  logic [`SSBI_DATA_W-1:0] last;

  initial begin
    addr_o = '0;
    // Advance from reset so the idle state sees a continue cycle first
    load_n_o = 1'h1;
    hold_o = 1'h0;
    cs_o = 3'h6;
    rd_o = 1'h1;
    bw_n_o = 2'h3;
    async_o = 3'h1;
    last = '0;
    wp = '{default: '0};
    xp = '{default: '0};
  end

  // Pipelines move on every edge without clock hold, even while the device sleeps
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xp[1] <= '0;
      xp[2] <= '0;
      xp[3] <= '0;
      wp[1] <= '0;
      wp[2] <= '0;
    end else if (!hold_o) begin
      xp[1] <= xp[0];
      xp[2] <= xp[1];
      xp[3] <= xp[2];
      wp[1] <= wp[0];
      wp[2] <= wp[1];
    end
  end

  // Undriven bus shows the inverse of its last level
  always @(posedge clk_i) last <= bus_o;
  assign bus_o = doe_i ? dout_i : wp[2][18] ? wp[2][17:0] : ~last;

  always @(negedge clk_i) begin
    if (nrst_i && xp[3][19]) begin
      tb.check("drive", {17'h0, doe_i}, {17'h0, xp[3][18]});
      if (xp[3][18]) tb.check("rdata", dout_i, xp[3][17:0]);
    end
    if (wp[2][18]) tb.check("turnaround", {17'h0, doe_i}, 18'h0);
  end

  task automatic issue(input logic v, input logic [2:0] c, input logic r,
      input logic [1:0] b, input logic [20:0] a, input logic [18:0] d,
      input logic [18:0] q);
    @(posedge clk_i);
    load_n_o <= v;
    cs_o <= c;
    rd_o <= r;
    bw_n_o <= b;
    addr_o <= a;
    hold_o <= 1'h0;
    wp[0] <= d;
    xp[0] <= {1'h1, q};
  endtask

  task automatic stall(input int n);
    repeat (n) begin
      @(posedge clk_i);
      hold_o <= 1'h1;
    end
  endtask

  // Applied right after an issue; spacing is the caller's duty
  task automatic pins(input logic [2:0] p);
    async_o <= p;
  endtask
endmodule // ssbi_host

// File: verification/tb.sv
// Self-checking bench for the burst memory device
`timescale 1ns/10ps
`include "ssbi_defs.svh"
module tb;
  logic                    clk = 1'h0;
  logic                    nrst = 1'h0;
  logic [`SSBI_ADDR_W-1:0] addr;
  logic                    load_n;
  logic                    hold;
  logic [2:0]              cs;
  logic                    rd;
  logic [1:0]              bwn;
  logic [2:0]              asy;
  logic [`SSBI_DATA_W-1:0] bus;
  logic [`SSBI_DATA_W-1:0] dout;
  logic                    doe;
  logic                    slp;
  int                      errors = 0;
  int                      check_count = 0;
  logic [17:0]             mem [int];
  logic [20:0]             base = '0;
  int                      n;
  int                      bt;
  logic                    lin = 1'h0;
  logic                    oel = 1'h1;

  always #20 clk = ~clk;

  ssbi_top DUT (
    .CORE_CLK_I           (clk),
    .NRST_I               (nrst),
    .ADDR_I               (addr),
    .BURST_STEP_OR_LOAD_I (load_n),
    .CLOCK_HOLD_N_I       (hold),
    .CHIP_SELECT_A_N_I    (cs[2]),
    .CHIP_SELECT_B_I      (cs[1]),
    .CHIP_SELECT_C_N_I    (cs[0]),
    .READ_WRITE_N_I       (rd),
    .BYTE_WRITE_LO_N_I    (bwn[0]),
    .BYTE_WRITE_HI_N_I    (bwn[1]),
    .OUT_ENABLE_N_I       (asy[`SSBI_PIN_OE_N]),
    .BURST_ORDER_SELECT_I (asy[`SSBI_PIN_ORDER]),
    .SLEEP_REQUEST_I      (asy[`SSBI_PIN_SLEEP]),
    .DATA_I               (bus),
    .DATA_O               (dout),
    .DATA_OE_O            (doe),
    .SLEEP_ACTIVE_O       (slp)
  );

  ssbi_host HOST (
    .clk_i   (clk),
    .nrst_i  (nrst),
    .addr_o  (addr),
    .load_n_o (load_n),
    .hold_o  (hold),
    .cs_o    (cs),
    .rd_o    (rd),
    .bw_n_o  (bwn),
    .async_o (asy),
    .bus_o   (bus),
    .dout_i  (dout),
    .doe_i   (doe)
  );

  task automatic check(input string nm, input logic [17:0] s,
      input logic [17:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Models the burst address and storage, then hands the cycle over
  task automatic op(input logic v, input logic [2:0] c, input logic r,
      input logic [1:0] b, input logic [20:0] a, input logic [17:0] s);
    logic [20:0] ad;
    logic [17:0] wd;
    if (!v) begin
      base = a;
      n = 0;
      bt = c != 3'h2 ? 0 : r ? 1 : 2;
    end else if (bt != 0) n++;
    ad = {base[20:2], lin ? base[1:0] + n[1:0] : base[1:0] ^ n[1:0]};
    wd = s ^ {ad[8:0], ad[8:0]};
    if (bt == 2 && !b[0]) mem[ad][8:0] = wd[8:0];
    if (bt == 2 && !b[1]) mem[ad][17:9] = wd[17:9];
    HOST.issue(v, c, r, b, a, {bt == 2 && b != 2'h3, wd},
               {bt == 1 && oel, mem.exists(ad) ? mem[ad] : 18'h0});
  endtask

  // Advances carry a wrong type, address and selects on purpose
  task automatic burst(input logic r, input logic [20:0] a,
      input logic [1:0] b, input logic [17:0] s, input int h);
    op(1'h0, 3'h2, r, b, a, s);
    HOST.stall(h);
    repeat (4) op(1'h1, 3'h5, ~r, b, ~a, s);
    if (r) gap(1);
  endtask

  task automatic gap(input int k);
    repeat (k) op(1'h0, 3'h6, 1'h1, 2'h3, 21'h0, 18'h0);
  endtask

  task automatic wait_slp(input logic v);
    for (int i = 0; i < 8; i++) begin
      gap(1);
      @(negedge clk);
      if (slp === v) break;
    end
    check("sleep flag", {17'h0, slp}, {17'h0, v});
  endtask

  task automatic t_power;
    @(negedge clk);
    check("float", {17'h0, doe}, 18'h0);
    repeat (2) op(1'h1, 3'h2, 1'h1, 2'h0, 21'h0, 18'h0);
    gap(2);
    $display("test power done");
  endtask

  task automatic t_bursts;
    for (int l = 0; l < 2; l++) begin
      lin = (l == 1);
      HOST.pins({2'h0, ~lin});
      gap(5);
      for (int s = 0; s < 4; s++) begin
        burst(1'h0, 21'h15a30 + 21'(s * 5), 2'h0, 18'h2c3a5, 0);
        burst(1'h1, 21'h15a30 + 21'(s * 5), 2'h3, 18'h0, 0);
      end
    end
    $display("test bursts done");
  endtask

  task automatic t_lanes;
    burst(1'h0, 21'h0c100, 2'h0, 18'h11111, 0);
    burst(1'h0, 21'h0c100, 2'h2, 18'h2a2a2, 0);
    burst(1'h0, 21'h0c100, 2'h1, 18'h35353, 0);
    burst(1'h0, 21'h0c100, 2'h3, 18'h3ffff, 0);
    burst(1'h1, 21'h0c100, 2'h3, 18'h0, 0);
    $display("test lanes done");
  endtask

  task automatic t_oe;
    gap(3);
    HOST.pins({2'h1, ~lin});
    oel = 1'h0;
    gap(5);
    burst(1'h1, 21'h0c100, 2'h3, 18'h0, 0);
    HOST.pins({2'h0, ~lin});
    gap(5);
    oel = 1'h1;
    burst(1'h0, 21'h0c104, 2'h0, 18'h0f0f0, 0);
    burst(1'h1, 21'h0c104, 2'h3, 18'h0, 0);
    $display("test output enable done");
  endtask

  task automatic t_desel;
    for (int i = 0; i < 3; i++) begin
      op(1'h0, 3'h2, 1'h1, 2'h3, 21'h0c100, 18'h0);
      op(1'h1, 3'h2, 1'h0, 2'h3, 21'h0, 18'h0);
      op(1'h0, 3'h6 >> i, 1'h1, 2'h3, 21'h0c101, 18'h0);
      repeat (2) op(1'h1, 3'h2, 1'h1, 2'h3, 21'h0, 18'h0);
    end
    $display("test deselect done");
  endtask

  task automatic t_hold;
    burst(1'h1, 21'h15a30, 2'h3, 18'h0, 3);
    burst(1'h0, 21'h0c108, 2'h0, 18'h01234, 2);
    burst(1'h1, 21'h0c108, 2'h3, 18'h0, 0);
    $display("test hold done");
  endtask

  // Requests only with nothing in flight, and settles after wake
  task automatic t_sleep;
    gap(3);
    HOST.pins({2'h2, ~lin});
    wait_slp(1'h1);
    HOST.issue(1'h0, 3'h2, 1'h0, 2'h0, 21'h0c100, {1'h1, 18'h0}, 19'h0);
    HOST.issue(1'h0, 3'h2, 1'h1, 2'h3, 21'h0c100, 19'h0, 19'h0);
    gap(3);
    HOST.pins({2'h0, ~lin});
    wait_slp(1'h0);
    gap(2);
    burst(1'h1, 21'h0c100, 2'h3, 18'h0, 0);
    $display("test sleep done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    t_power();
    t_bursts();
    t_lanes();
    t_oe();
    t_desel();
    t_hold();
    t_sleep();
    gap(4);
    give_verdict();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule // tb
